/* logic/mcu_multiplexed_host_port.sv */
`timescale 1ns/1ps
module mcu_multiplexed_host_port
    import mcu_port_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // microcontroller bus
    input  wire logic              chip_select_i,
    input  wire logic              bus_style_select_i,
    input  wire logic              addr_latch_i,
    input  wire logic              write_strobe_or_dir_i,
    input  wire logic              read_strobe_or_data_strobe_i,
    input  wire logic [DATA_W-1:0] mux_addr_data_in_i,
    output logic      [DATA_W-1:0] mux_addr_data_out_o,
    output logic                   mux_addr_data_oe_o,
    output logic                   ready_o,
    // register side
    output logic      [ADDR_W-1:0] reg_addr_o,
    output logic      [DATA_W-1:0] reg_wdata_o,
    output logic                   reg_write_o,
    output logic                   reg_read_o,
    input  wire logic [DATA_W-1:0] reg_rdata_i,
    // interrupt sources and drive configuration
    input  wire logic              disk_irq_req_i,
    input  wire logic              host_irq_req_i,
    input  wire logic              irq_cfg_valid_i,
    input  wire logic              disk_irq_open_drain_i,
    input  wire logic              host_irq_open_drain_i,
    // interrupt pins, active low
    output logic                   disk_irq_n_o,
    output logic                   disk_irq_n_oe_o,
    output logic                   host_irq_n_o,
    output logic                   host_irq_n_oe_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    acc_state_t              state_ff,   nxt_state;
    logic [1:0]              wait_ff,    nxt_wait;
    logic                    ale_ff,     nxt_ale;
    logic [ADDR_W-1:0]       addr_ff,    nxt_addr;
    logic                    is_rd_ff,   nxt_is_rd;
    logic [DATA_W-1:0]       dout_ff,    nxt_dout;
    logic                    doe_ff,     nxt_doe;
    logic                    rdy_ff,     nxt_rdy;
    logic [DATA_W-1:0]       wdata_ff,   nxt_wdata;
    logic                    wr_ff,      nxt_wr;
    logic                    rd_ff,      nxt_rd;
    logic                    cfg_ff,     nxt_cfg;
    logic                    dod_ff,     nxt_dod;
    logic                    hod_ff,     nxt_hod;
    logic                    dirq_ff,    nxt_dirq;
    logic                    dirq_oe_ff, nxt_dirq_oe;
    logic                    hirq_ff,    nxt_hirq;
    logic                    hirq_oe_ff, nxt_hirq_oe;
    logic                    rd_req, wr_req;
    // pin level and enable for an active-low interrupt pin
    function automatic logic [1:0] irq_drive(input logic cfg, input logic od,
                                             input logic req);
        // {level, enable}; open drain only pulls low
        if (!cfg)
            irq_drive = 2'b10;
        else if (od)
            irq_drive = {1'b0, req};
        else
            irq_drive = {~req, 1'b1};
    endfunction : irq_drive

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    // strobe decode per bus style, gated by chip select
    always_comb begin
        if (bus_style_select_i) begin
            rd_req = chip_select_i && !read_strobe_or_data_strobe_i;
            wr_req = chip_select_i && !write_strobe_or_dir_i;
        end else begin
            rd_req = chip_select_i && read_strobe_or_data_strobe_i
                     && write_strobe_or_dir_i;
            wr_req = chip_select_i && read_strobe_or_data_strobe_i
                     && !write_strobe_or_dir_i;
        end
    end

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    // next values of address latch, sequencer and data drive
    always_comb begin
        nxt_state = state_ff;
        nxt_wait  = wait_ff;
        nxt_ale   = addr_latch_i;
        nxt_addr  = addr_ff;
        nxt_is_rd = is_rd_ff;
        nxt_dout  = dout_ff;
        nxt_doe   = 1'b0;
        nxt_rdy   = 1'b1;
        nxt_wdata = wdata_ff;
        nxt_wr    = 1'b0;
        nxt_rd    = 1'b0;
        if (ale_ff && !addr_latch_i)
            nxt_addr = mux_addr_data_in_i;
        case (state_ff)
            ST_IDLE: begin
                if (rd_req || wr_req) begin
                    nxt_state = ST_WAIT;
                    nxt_wait  = WAIT_CYCLES;
                    nxt_is_rd = rd_req;
                    nxt_rdy   = 1'b0;
                end
            end
            ST_WAIT: begin
                if (!(rd_req || wr_req)) begin
                    nxt_state = ST_IDLE; // strobe withdrawn early
                end else if (wait_ff == 2'h0) begin
                    nxt_state = ST_DONE;
                    nxt_wr    = !is_rd_ff;
                    nxt_rd    = is_rd_ff;
                    nxt_wdata = mux_addr_data_in_i;
                    nxt_dout  = reg_rdata_i;
                    nxt_doe   = is_rd_ff;
                end else begin
                    nxt_wait = wait_ff - 2'h1;
                    nxt_rdy  = 1'b0;
                end
            end
            ST_DONE: begin // held until the strobe ends, one access only
                if (rd_req || wr_req) begin
                    nxt_doe = is_rd_ff && rd_req;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end
    // registers of the sequencer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_IDLE;
            wait_ff  <= 2'h0;
            ale_ff   <= 1'b0;
            addr_ff  <= ADDR_RST;
            is_rd_ff <= 1'b0;
            dout_ff  <= DATA_RST;
            doe_ff   <= 1'b0;
            rdy_ff   <= 1'b0; // ready deasserted while in reset
            wdata_ff <= DATA_RST;
            wr_ff    <= 1'b0;
            rd_ff    <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            wait_ff  <= nxt_wait;
            ale_ff   <= nxt_ale;
            addr_ff  <= nxt_addr;
            is_rd_ff <= nxt_is_rd;
            dout_ff  <= nxt_dout;
            doe_ff   <= nxt_doe;
            rdy_ff   <= nxt_rdy;
            wdata_ff <= nxt_wdata;
            wr_ff    <= nxt_wr;
            rd_ff    <= nxt_rd;
        end
    end

    // ------------------------------------------------------------
    // interrupt pins
    // ------------------------------------------------------------
    // drive configuration and pin levels
    always_comb begin
        nxt_cfg = cfg_ff | irq_cfg_valid_i;
        nxt_dod = irq_cfg_valid_i ? disk_irq_open_drain_i : dod_ff;
        nxt_hod = irq_cfg_valid_i ? host_irq_open_drain_i : hod_ff;
        {nxt_dirq, nxt_dirq_oe} = irq_drive(cfg_ff, dod_ff,
                                            disk_irq_req_i);
        {nxt_hirq, nxt_hirq_oe} = irq_drive(cfg_ff, hod_ff,
                                            host_irq_req_i);
    end
    // registers of the interrupt pins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_ff     <= 1'b0;
            dod_ff     <= 1'b0;
            hod_ff     <= 1'b0;
            dirq_ff    <= 1'b1;
            dirq_oe_ff <= 1'b0;
            hirq_ff    <= 1'b1;
            hirq_oe_ff <= 1'b0;
        end else begin
            cfg_ff     <= nxt_cfg;
            dod_ff     <= nxt_dod;
            hod_ff     <= nxt_hod;
            dirq_ff    <= nxt_dirq;
            dirq_oe_ff <= nxt_dirq_oe;
            hirq_ff    <= nxt_hirq;
            hirq_oe_ff <= nxt_hirq_oe;
        end
    end
    // outputs straight from flip-flops
    assign mux_addr_data_out_o = dout_ff;
    assign mux_addr_data_oe_o  = doe_ff;
    assign ready_o             = rdy_ff;
    assign reg_addr_o          = addr_ff;
    assign reg_wdata_o         = wdata_ff;
    assign reg_write_o         = wr_ff;
    assign reg_read_o          = rd_ff;
    assign disk_irq_n_o        = dirq_ff;
    assign disk_irq_n_oe_o     = dirq_oe_ff;
    assign host_irq_n_o        = hirq_ff;
    assign host_irq_n_oe_o     = hirq_oe_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_cs_gate;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == ST_IDLE && !chip_select_i) |=> rdy_ff;
    endproperty
    a_cs_gate: assert property (p_cs_gate)
        else $error("access started without chip select");
    property p_sep_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == ST_IDLE && bus_style_select_i && chip_select_i
         && !write_strobe_or_dir_i && read_strobe_or_data_strobe_i)
        ##1 (wr_req [*3]) |=> reg_write_o;
    endproperty
    a_sep_write: assert property (p_sep_write)
        else $error("separate style write not performed");
    property p_dir_read;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == ST_IDLE && !bus_style_select_i && rd_req)
        ##1 (rd_req [*3]) |=> (reg_read_o && mux_addr_data_oe_o);
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction style read not performed");
    property p_ready_low;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == ST_IDLE && (rd_req || wr_req)) |=> !ready_o;
    endproperty
    a_ready_low: assert property (p_ready_low)
        else $error("ready not lowered at access start");
    property p_addr_latch;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ale_ff && !addr_latch_i) |=>
            (reg_addr_o == $past(mux_addr_data_in_i));
    endproperty
    a_addr_latch: assert property (p_addr_latch)
        else $error("address not latched on strobe trailing edge");
    property p_irq_float;
        @(posedge clk_i) disable iff (!rst_n_i)
        !cfg_ff |=> (!disk_irq_n_oe_o && !host_irq_n_oe_o);
    endproperty
    a_irq_float: assert property (p_irq_float)
        else $error("interrupt pin driven before configuration");
    property p_reset_float;
        @(posedge clk_i)
        !rst_n_i |=> (!mux_addr_data_oe_o && !disk_irq_n_oe_o
                      && !host_irq_n_oe_o && !ready_o && !reg_write_o);
    endproperty
    a_reset_float: assert property (p_reset_float)
        else $error("pins driven during reset");
    property p_drive_read;
        @(posedge clk_i) disable iff (!rst_n_i)
        mux_addr_data_oe_o |-> is_rd_ff;
    endproperty
    a_drive_read: assert property (p_drive_read)
        else $error("data lines driven outside a read");
    property p_one_access;
        @(posedge clk_i) disable iff (!rst_n_i)
        (reg_write_o || reg_read_o) |=> !(reg_write_o || reg_read_o);
    endproperty
    a_one_access: assert property (p_one_access)
        else $error("more than one access per strobe");
    c_write: cover property (@(posedge clk_i) reg_write_o);
    c_read:  cover property (@(posedge clk_i) reg_read_o);
    c_dir_write: cover property (@(posedge clk_i)
                             !bus_style_select_i && reg_write_o);
    c_od:    cover property (@(posedge clk_i) dod_ff && disk_irq_n_oe_o);

endmodule : mcu_multiplexed_host_port

/* logic/mcu_port_pkg.sv */
package mcu_port_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    // wait count loaded when a strobe is seen; ready stays low one cycle longer than this
    localparam logic [1:0] WAIT_CYCLES = 2'h2;

    // ------------------------------------------------------------
    // access sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } acc_state_t;

endpackage : mcu_port_pkg

/* verif/mcu_bus_model.sv */
`timescale 1ns/1ps
// local microcontroller on the multiplexed bus
module mcu_bus_model (
    // clock and device answers
    input  wire logic       clk_i,
    input  wire logic       ready_i,
    input  wire logic [7:0] bus_i,
    // bus controls
    output logic            cs_o,
    output logic            style_o,
    output logic            ale_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      drv_o
);
    // power-up: separate strobes, nothing selected
    initial begin
        cs_o = 1'b0;
        style_o = 1'b1;
        ale_o = 1'b0;
        wr_o = 1'b1;
        rd_o = 1'b1;
        drv_o = 8'h00;
    end

    // drop strobes; a released bus shows the inverse pattern
    task idle();
        cs_o = 1'b0;
        wr_o = 1'b1;
        rd_o = style_o;
        drv_o = ~drv_o;
    endtask : idle

    // raise one request in the current bus style
    task strobe(input logic rd, input logic cs);
        cs_o = cs;
        wr_o = rd;
        rd_o = style_o ? ~rd : 1'b1;
    endtask : strobe

    task set_style(input logic s);
        @(negedge clk_i);
        style_o = s;
        rd_o = s;
    endtask : set_style

    // address phase, held two cycles past the latch edge
    task latch(input logic [7:0] a);
        @(negedge clk_i);
        ale_o = 1'b1;
        drv_o = a;
        @(negedge clk_i);
        ale_o = 1'b0;
        repeat (2) @(negedge clk_i);
        drv_o = ~a;
    endtask : latch

    // full access: wait states inserted while ready is low
    task access(input logic rd, input logic [7:0] wd,
                output logic [7:0] q, output int nl, output bit ok);
        bit seen;
        @(negedge clk_i);
        drv_o = rd ? ~drv_o : wd;
        strobe(rd, 1'b1);
        nl = 0;
        seen = 0;
        ok = 0;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge clk_i);
            if (ready_i === 1'b0) begin
                seen = 1;
                nl++;
            end else if (seen) begin
                ok = 1;
                q = bus_i;
            end
        end
        @(negedge clk_i);
        idle();
    endtask : access

    // strobe held a fixed number of cycles
    task hold(input logic rd, input logic cs, input int n);
        @(negedge clk_i);
        drv_o = 8'h96;
        strobe(rd, cs);
        repeat (n) @(negedge clk_i);
        idle();
    endtask : hold
endmodule : mcu_bus_model

/* verif/mcu_multiplexed_host_port_tb_top.sv */
`timescale 1ns/1ps
module mcu_multiplexed_host_port_tb_top;
    import mcu_port_pkg::*;
    logic       clk_i, rst_n_i, chip_select_i, bus_style_select_i;
    logic       addr_latch_i, write_strobe_or_dir_i;
    logic       read_strobe_or_data_strobe_i, mux_addr_data_oe_o;
    logic       ready_o, reg_write_o, reg_read_o, irq_cfg_valid_i;
    logic       disk_irq_req_i, host_irq_req_i, disk_irq_open_drain_i;
    logic       host_irq_open_drain_i, disk_irq_n_o, disk_irq_n_oe_o;
    logic       host_irq_n_o, host_irq_n_oe_o;
    logic [7:0] mux_addr_data_in_i, mux_addr_data_out_o, reg_addr_o;
    logic [7:0] reg_wdata_o, reg_rdata_i, mcu_drv;
    logic [7:0] regs [256];
    int         n_fail, num_checks, n_wr, n_rd, n_low;

    // wire level from both drivers
    assign mux_addr_data_in_i = mux_addr_data_oe_o ? mux_addr_data_out_o
                                                   : mcu_drv;
    assign reg_rdata_i = regs[reg_addr_o];

    mcu_multiplexed_host_port u_mcu_multiplexed_host_port (
        .clk_i, .rst_n_i, .chip_select_i, .bus_style_select_i,
        .addr_latch_i, .write_strobe_or_dir_i,
        .read_strobe_or_data_strobe_i, .mux_addr_data_in_i,
        .mux_addr_data_out_o, .mux_addr_data_oe_o, .ready_o,
        .reg_addr_o, .reg_wdata_o, .reg_write_o, .reg_read_o,
        .reg_rdata_i, .disk_irq_req_i, .host_irq_req_i,
        .irq_cfg_valid_i, .disk_irq_open_drain_i,
        .host_irq_open_drain_i, .disk_irq_n_o, .disk_irq_n_oe_o,
        .host_irq_n_o, .host_irq_n_oe_o);

    mcu_bus_model u_mcu_bus_model (
        .clk_i   (clk_i),
        .ready_i (ready_o),
        .bus_i   (mux_addr_data_in_i),
        .cs_o    (chip_select_i),
        .style_o (bus_style_select_i),
        .ale_o   (addr_latch_i),
        .wr_o    (write_strobe_or_dir_i),
        .rd_o    (read_strobe_or_data_strobe_i),
        .drv_o   (mcu_drv));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // register file and event counters
    always @(posedge clk_i) begin
        if (reg_write_o === 1'b1) begin
            regs[reg_addr_o] <= reg_wdata_o;
            n_wr++;
        end
        if (reg_read_o === 1'b1) n_rd++;
        if (ready_o === 1'b0) n_low++;
    end

    task chk8(input string w, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", w, e, g);
            n_fail++;
        end
    endtask : chk8

    task chk1(input string w, input logic e, input logic g);
        chk8(w, {7'h00, e}, {7'h00, g});
    endtask : chk1

    task conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task do_reset();
        rst_n_i = 1'b0;
        repeat (12) @(negedge clk_i);
        chk1("rst_oe", 1'b0, mux_addr_data_oe_o);
        chk1("rst_rdy", 1'b0, ready_o);
        chk1("rst_doe", 1'b0, disk_irq_n_oe_o);
        chk1("rst_hoe", 1'b0, host_irq_n_oe_o);
        chk1("rst_wr", 1'b0, reg_write_o);
        rst_n_i = 1'b1;
        $display("test reset done");
    endtask : do_reset

    // write then read back one register
    task t_rw(input logic st, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        int nl, w0, r0;
        bit ok;
        u_mcu_bus_model.set_style(st);
        u_mcu_bus_model.latch(a);
        chk8("addr", a, reg_addr_o);
        w0 = n_wr;
        r0 = n_rd;
        u_mcu_bus_model.access(1'b0, d, q, nl, ok);
        chk1("wr_done", 1'b1, ok);
        if (!ok) conclude();
        chk8("wr_cnt", 8'(w0 + 1), 8'(n_wr));
        chk8("wr_data", d, regs[a]);
        chk8("wait", 8'(WAIT_CYCLES + 1), 8'(nl));
        chk1("oe_wr", 1'b0, mux_addr_data_oe_o);
        u_mcu_bus_model.latch(a);
        u_mcu_bus_model.access(1'b1, 8'h00, q, nl, ok);
        chk1("rd_done", 1'b1, ok);
        if (!ok) conclude();
        chk8("rd_data", d, q);
        chk8("rd_cnt", 8'(r0 + 1), 8'(n_rd));
        repeat (2) @(negedge clk_i);
        chk1("oe_rel", 1'b0, mux_addr_data_oe_o);
        $display("test rw style %0b done", st);
    endtask : t_rw

    // ignored, aborted and over-long strobes
    task t_refuse();
        int w0, l0, r0;
        w0 = n_wr;
        l0 = n_low;
        r0 = n_rd;
        u_mcu_bus_model.hold(1'b0, 1'b0, 8);
        chk8("cs_wr", 8'(w0), 8'(n_wr));
        chk8("cs_rdy", 8'(l0), 8'(n_low));
        u_mcu_bus_model.hold(1'b0, 1'b1, 2);
        repeat (6) @(negedge clk_i);
        chk8("abort", 8'(w0), 8'(n_wr));
        u_mcu_bus_model.hold(1'b0, 1'b1, 12);
        chk8("held_wr", 8'(w0 + 1), 8'(n_wr));
        u_mcu_bus_model.hold(1'b1, 1'b1, 12);
        chk8("held_rd", 8'(r0 + 1), 8'(n_rd));
        repeat (2) @(negedge clk_i);
        chk1("oe_idle", 1'b0, mux_addr_data_oe_o);
        $display("test refuse done");
    endtask : t_refuse

    // interrupt pins: floating, push-pull, open-drain
    task t_irq();
        logic od;
        disk_irq_req_i = 1'b1;
        host_irq_req_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk1("dirq_oe0", 1'b0, disk_irq_n_oe_o);
        chk1("hirq_oe0", 1'b0, host_irq_n_oe_o);
        for (int m = 0; m < 2; m++) begin
            od = m[0];
            disk_irq_open_drain_i = od;
            host_irq_open_drain_i = ~od;
            irq_cfg_valid_i = 1'b1;
            @(negedge clk_i);
            irq_cfg_valid_i = 1'b0;
            for (int q = 1; q >= 0; q--) begin
                disk_irq_req_i = q[0];
                host_irq_req_i = q[0];
                repeat (3) @(negedge clk_i);
                chk1("dirq_oe", od ? q[0] : 1'b1, disk_irq_n_oe_o);
                chk1("dirq", od ? 1'b0 : ~q[0], disk_irq_n_o);
                chk1("hirq_oe", od ? 1'b1 : q[0], host_irq_n_oe_o);
                chk1("hirq", od ? ~q[0] : 1'b0, host_irq_n_o);
            end
            disk_irq_req_i = 1'b1;
            host_irq_req_i = 1'b1;
            do_reset();
        end
        $display("test irq done");
    endtask : t_irq

    // main sequence
    initial begin
        n_fail = 0;
        num_checks = 0;
        n_wr = 0;
        n_rd = 0;
        n_low = 0;
        rst_n_i = 1'b0;
        disk_irq_req_i = 1'b0;
        host_irq_req_i = 1'b0;
        irq_cfg_valid_i = 1'b0;
        disk_irq_open_drain_i = 1'b0;
        host_irq_open_drain_i = 1'b0;
        do_reset();
        t_rw(1'b1, 8'hFF, 8'h3C);
        t_rw(1'b0, 8'h00, 8'hC3);
        t_refuse();
        t_irq();
        conclude();
    end
endmodule : mcu_multiplexed_host_port_tb_top
